// ---- hdl/pmic_telemetry_and_error_injection.sv ----
// telemetry readout, address id strap sensing and error injection control
//
// Function
// - adc_control[7:3] enables the ADC and selects the converted voltage rail.
// - selected rail voltage result appears in adc_voltage_result[7:0].
// - rail A result in rail_a_current_power[7:0], B in rail_b_current_power[5:0], C in rail_c_current_power[5:0], continuously.
// - current_power_select[6] selects current (0) or power (1) reporting.
// - adc_control[1:0] sets averaging window and refresh rate of telemetry registers.
// - with power selected, power_sum_select[1]=1 puts summed buck power into rail A register.
// - die temperature reported as three-bit code in die_temperature_result[7:5].
// - temperature conversion runs by itself while die is above 85 C.
// - strap sensed at power-up: ground 1001, floating 1000, ldo 1100.
// - pre-on injected listed error blocks power-on, outputs stay disabled.
// - pre-on injection leaves error logs error_log_first to error_log_third unchanged.
// - after pre-on injection, secure mode if mode_after_injection_select[2]=0, programmable if 1.
// - with regulators running, injection enable write honoured only in programmable mode.
// - injected error while running starts power-off, updates logs and status.
// - injection mode held until bulk supply power cycle; writes cannot exit.
module pmic_telemetry_and_error_injection (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] adc_voltage_code_in,
    input wire logic [7:0] rail_a_buck_current_in,
    input wire logic [5:0] rail_b_buck_current_in,
    input wire logic [5:0] rail_c_buck_current_in,
    input wire logic [7:0] rail_a_buck_power_in,
    input wire logic [5:0] rail_b_buck_power_in,
    input wire logic [5:0] rail_c_buck_power_in,
    input wire logic [2:0] die_temp_code_in,
    input wire logic die_temp_above_85c_in,
    input wire logic [1:0] address_id_strap_in,
    input wire logic regulator_on_command_in,
    input wire logic programmable_mode_in,
    output logic adc_enable_out,
    output logic [3:0] adc_channel_out,
    output logic temp_convert_out,
    output logic [3:0] address_id_out,
    output logic regulators_enable_out,
    output logic power_off_start_out,
    output logic injection_mode_out,
    output logic programmable_mode_out,
    output logic [2:0] fault_status_out
);

    `include "pmic_telemetry_cfg.svh"

    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // log2 of window: 2, 4, 8 or 16 samples
    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        avg_shift = {1'b0, sel} + 3'h1;
    endfunction

    // ----------------------------------------
    // host configuration registers
    // ----------------------------------------
    logic [7:0] adc_control_q;
    logic power_sum_q;
    logic current_power_q;
    logic mode_select_q;
    logic [7:0] inj_control_q;
    pmic_telemetry_pkg::reg_state_type state_q;
    logic prog_mode_q;
    logic wr_adc;
    logic wr_inj;
    logic inj_write_ok;

    assign wr_adc = reg_write_in && (reg_addr_in == `OFS_ADC_CONTROL);
    assign wr_inj = reg_write_in && (reg_addr_in == `OFS_ERROR_INJECTION_CONTROL);
    // setup allowed in config state, else only in programmable mode
    assign inj_write_ok = (state_q == pmic_telemetry_pkg::ST_CONFIG) || prog_mode_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            adc_control_q <= `REG_BYTE_RESET;
        end else if (wr_adc) begin
            adc_control_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            power_sum_q <= 1'b0;
            current_power_q <= 1'b0;
            mode_select_q <= 1'b0;
        end else if (reg_write_in) begin
            if (reg_addr_in == `OFS_POWER_SUM_SELECT) begin
                power_sum_q <= reg_wdata_in[`POWER_SUM_BIT];
            end
            if (reg_addr_in == `OFS_CURRENT_POWER_SELECT) begin
                current_power_q <= reg_wdata_in[`CURRENT_POWER_BIT];
            end
            if (reg_addr_in == `OFS_MODE_AFTER_INJECTION_SELECT) begin
                mode_select_q <= reg_wdata_in[`MODE_SELECT_BIT];
            end
        end
    end

    // enable bit is sticky: only a bulk power cycle (reset) clears it
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            inj_control_q <= `REG_BYTE_RESET;
        end else if (wr_inj && inj_write_ok) begin
            inj_control_q[`INJ_ENABLE_BIT] <= inj_control_q[`INJ_ENABLE_BIT] | reg_wdata_in[`INJ_ENABLE_BIT];
            inj_control_q[`INJ_TEMP_BIT:`INJ_BULK_BIT] <= reg_wdata_in[`INJ_TEMP_BIT:`INJ_BULK_BIT];
        end
    end

    assign adc_enable_out = adc_control_q[`ADC_ENABLE_BIT];
    assign adc_channel_out = adc_control_q[`ADC_SELECT_MSB:`ADC_SELECT_LSB];
    assign injection_mode_out = inj_control_q[`INJ_ENABLE_BIT];
    assign programmable_mode_out = prog_mode_q;

    // ----------------------------------------
    // sample timer and averaging
    // ----------------------------------------
    localparam int SAMPLE_LAST = `SAMPLE_CYCLES - 1;
    logic [9:0] tick_cnt_q;
    logic tick;
    logic [3:0] win_cnt_q;
    logic [2:0] shift;
    logic win_end;
    logic [9:0] power_total;
    logic [7:0] sample_a;
    logic [5:0] sample_b;
    logic [5:0] sample_c;
    logic [11:0] acc_a_q;
    logic [9:0] acc_b_q;
    logic [9:0] acc_c_q;
    logic [11:0] acc_a_d;
    logic [9:0] acc_b_d;
    logic [9:0] acc_c_d;
    logic [7:0] rail_a_q;
    logic [5:0] rail_b_q;
    logic [5:0] rail_c_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_cnt_q <= 10'h000;
        end else if (tick) begin
            tick_cnt_q <= 10'h000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 10'h001;
        end
    end

    assign tick = (tick_cnt_q == SAMPLE_LAST[9:0]);
    assign shift = avg_shift(adc_control_q[`AVG_WINDOW_MSB:`AVG_WINDOW_LSB]);
    assign win_end = tick && (win_cnt_q == 4'((5'h01 << shift) - 5'h01));

    // summed power saturates at the rail A register width
    assign power_total = {2'h0, rail_a_buck_power_in} + {4'h0, rail_b_buck_power_in} + {4'h0, rail_c_buck_power_in};

    always_comb begin
        if (!current_power_q) begin
            sample_a = rail_a_buck_current_in;
            sample_b = rail_b_buck_current_in;
            sample_c = rail_c_buck_current_in;
        end else begin
            sample_b = rail_b_buck_power_in;
            sample_c = rail_c_buck_power_in;
            if (power_sum_q) begin
                sample_a = (power_total > 10'h0FF) ? 8'hFF : power_total[7:0];
            end else begin
                sample_a = rail_a_buck_power_in;
            end
        end
    end

    assign acc_a_d = acc_a_q + {4'h0, sample_a};
    assign acc_b_d = acc_b_q + {4'h0, sample_b};
    assign acc_c_d = acc_c_q + {4'h0, sample_c};

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            win_cnt_q <= 4'h0;
            acc_a_q <= 12'h000;
            acc_b_q <= 10'h000;
            acc_c_q <= 10'h000;
        end else if (wr_adc) begin
            // a new window setting restarts the running average
            win_cnt_q <= 4'h0;
            acc_a_q <= 12'h000;
            acc_b_q <= 10'h000;
            acc_c_q <= 10'h000;
        end else if (win_end) begin
            win_cnt_q <= 4'h0;
            acc_a_q <= 12'h000;
            acc_b_q <= 10'h000;
            acc_c_q <= 10'h000;
        end else if (tick) begin
            win_cnt_q <= win_cnt_q + 4'h1;
            acc_a_q <= acc_a_d;
            acc_b_q <= acc_b_d;
            acc_c_q <= acc_c_d;
        end
    end

    // results refresh once per window, never from host writes
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rail_a_q <= `REG_BYTE_RESET;
            rail_b_q <= 6'h00;
            rail_c_q <= 6'h00;
        end else if (win_end && !wr_adc) begin
            rail_a_q <= 8'(acc_a_d >> shift);
            rail_b_q <= 6'(acc_b_d >> shift);
            rail_c_q <= 6'(acc_c_d >> shift);
        end
    end

    // ----------------------------------------
    // voltage and temperature conversions
    // ----------------------------------------
    logic [7:0] voltage_q;
    logic [2:0] temp_q;

    assign temp_convert_out = die_temp_above_85c_in || adc_control_q[`ADC_ENABLE_BIT];

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            voltage_q <= `REG_BYTE_RESET;
        end else if (tick && adc_control_q[`ADC_ENABLE_BIT]) begin
            voltage_q <= adc_voltage_code_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            temp_q <= 3'h0;
        end else if (tick && temp_convert_out) begin
            temp_q <= die_temp_code_in;
        end
    end

    // ----------------------------------------
    // address id strap
    // ----------------------------------------
    logic strap_done_q;
    logic [3:0] id_q;

    // strap caught once after reset release
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_done_q <= 1'b0;
            id_q <= `ID_STRAP_FLOAT;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            case (pmic_telemetry_pkg::strap_type'(address_id_strap_in))
                pmic_telemetry_pkg::STRAP_GROUND: id_q <= `ID_STRAP_GROUND;
                pmic_telemetry_pkg::STRAP_LDO: id_q <= `ID_STRAP_LDO;
                default: id_q <= `ID_STRAP_FLOAT;
            endcase
        end
    end

    assign address_id_out = id_q;

    // ----------------------------------------
    // error injection and sequencing
    // ----------------------------------------
    logic inj_armed;
    logic [7:0] log_first_q;
    logic [7:0] log_second_q;
    logic [7:0] log_third_q;
    logic [2:0] fault_q;
    logic power_off_q;
    logic enter_fault;

    assign inj_armed = inj_control_q[`INJ_ENABLE_BIT] && (|inj_control_q[`INJ_TEMP_BIT:`INJ_BULK_BIT]);
    assign enter_fault = (state_q == pmic_telemetry_pkg::ST_ON) && inj_armed;

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= pmic_telemetry_pkg::ST_CONFIG;
        end else begin
            case (state_q)
                pmic_telemetry_pkg::ST_CONFIG: begin
                    if (regulator_on_command_in) begin
                        if (inj_armed) begin
                            state_q <= pmic_telemetry_pkg::ST_BLOCKED;
                        end else begin
                            state_q <= pmic_telemetry_pkg::ST_ON;
                        end
                    end
                end
                pmic_telemetry_pkg::ST_ON: begin
                    if (enter_fault) begin
                        state_q <= pmic_telemetry_pkg::ST_OFF_FAULT;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // mode frozen by select bit after pre-on injection
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prog_mode_q <= 1'b0;
        end else if (state_q == pmic_telemetry_pkg::ST_BLOCKED) begin
            prog_mode_q <= prog_mode_q;
        end else if (state_q == pmic_telemetry_pkg::ST_CONFIG && regulator_on_command_in && inj_armed) begin
            prog_mode_q <= mode_select_q;
        end else begin
            prog_mode_q <= programmable_mode_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            regulators_enable_out <= 1'b0;
            power_off_q <= 1'b0;
        end else begin
            regulators_enable_out <= (state_q == pmic_telemetry_pkg::ST_ON) && !enter_fault;
            power_off_q <= enter_fault;
        end
    end

    assign power_off_start_out = power_off_q;

    // logs move only on a running fault
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            log_first_q <= `REG_BYTE_RESET;
            log_second_q <= `REG_BYTE_RESET;
            log_third_q <= `REG_BYTE_RESET;
            fault_q <= 3'h0;
        end else if (enter_fault) begin
            log_first_q <= {5'h00, inj_control_q[`INJ_TEMP_BIT:`INJ_BULK_BIT]};
            log_second_q <= (log_second_q == 8'hFF) ? 8'hFF : log_second_q + 8'h01;
            log_third_q <= {7'h00, 1'b1};
            fault_q <= inj_control_q[`INJ_TEMP_BIT:`INJ_BULK_BIT];
        end
    end

    assign fault_status_out = fault_q;

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [7:0] rdata_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= `REG_BYTE_RESET;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                `OFS_ERROR_LOG_FIRST: rdata_q <= log_first_q;
                `OFS_ERROR_LOG_SECOND: rdata_q <= log_second_q;
                `OFS_ERROR_LOG_THIRD: rdata_q <= log_third_q;
                `OFS_RAIL_A_CURRENT_POWER: rdata_q <= rail_a_q;
                `OFS_RAIL_B_CURRENT_POWER: rdata_q <= {2'h0, rail_b_q};
                `OFS_RAIL_C_CURRENT_POWER: rdata_q <= {2'h0, rail_c_q};
                `OFS_POWER_SUM_SELECT: rdata_q <= {6'h00, power_sum_q, 1'b0};
                `OFS_CURRENT_POWER_SELECT: rdata_q <= {1'b0, current_power_q, 6'h00};
                `OFS_MODE_AFTER_INJECTION_SELECT: rdata_q <= {5'h00, mode_select_q, 2'h0};
                `OFS_ADC_CONTROL: rdata_q <= adc_control_q;
                `OFS_ADC_VOLTAGE_RESULT: rdata_q <= voltage_q;
                `OFS_DIE_TEMPERATURE_RESULT: rdata_q <= {temp_q, 5'h00};
                `OFS_ERROR_INJECTION_CONTROL: rdata_q <= inj_control_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out = rdata_q;

endmodule

// ---- hdl/pmic_telemetry_cfg.svh ----
// register offsets, field positions, reset values and timing counts of the telemetry block
`ifndef PMIC_TELEMETRY_CFG_SVH
`define PMIC_TELEMETRY_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_ERROR_LOG_FIRST 8'h04
`define OFS_ERROR_LOG_SECOND 8'h05
`define OFS_ERROR_LOG_THIRD 8'h06
`define OFS_RAIL_A_CURRENT_POWER 8'h0C
`define OFS_RAIL_B_CURRENT_POWER 8'h0E
`define OFS_RAIL_C_CURRENT_POWER 8'h0F
`define OFS_POWER_SUM_SELECT 8'h1A
`define OFS_CURRENT_POWER_SELECT 8'h1B
`define OFS_MODE_AFTER_INJECTION_SELECT 8'h2F
`define OFS_ADC_CONTROL 8'h30
`define OFS_ADC_VOLTAGE_RESULT 8'h31
`define OFS_DIE_TEMPERATURE_RESULT 8'h33
`define OFS_ERROR_INJECTION_CONTROL 8'h35

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADC_ENABLE_BIT 7
`define ADC_SELECT_MSB 6
`define ADC_SELECT_LSB 3
`define AVG_WINDOW_MSB 1
`define AVG_WINDOW_LSB 0
`define POWER_SUM_BIT 1
`define CURRENT_POWER_BIT 6
`define MODE_SELECT_BIT 2
`define INJ_ENABLE_BIT 7
`define INJ_BULK_BIT 0
`define INJ_RAIL_BIT 1
`define INJ_TEMP_BIT 2
`define TEMP_CODE_MSB 7
`define TEMP_CODE_LSB 5
`define RAIL_BC_MSB 5

// ----------------------------------------
// reset values and strap codes
// ----------------------------------------
`define REG_BYTE_RESET 8'h00
`define ID_STRAP_GROUND 4'h9
`define ID_STRAP_FLOAT 4'h8
`define ID_STRAP_LDO 4'hC

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define SAMPLE_PERIOD_NS 100000
`define SAMPLE_CYCLES ((`SAMPLE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- hdl/pmic_telemetry_pkg.sv ----
// types shared by the telemetry and error injection block
package pmic_telemetry_pkg;

    // regulator sequencing state
    typedef enum logic [1:0] {
        ST_CONFIG,
        ST_ON,
        ST_BLOCKED,
        ST_OFF_FAULT
    } reg_state_type;

    // sensed strap connection
    typedef enum logic [1:0] {
        STRAP_GROUND,
        STRAP_FLOAT,
        STRAP_LDO,
        STRAP_UNUSED
    } strap_type;

endpackage

// ---- test/host_bus_model.sv ----
// host model issuing single byte register accesses
module host_bus_model (
    input wire logic ref_clk_in,
    output logic [7:0] reg_addr_out,
    output logic reg_write_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_read_out,
    input wire logic [7:0] reg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr_out = 8'h00;
        reg_write_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_read_out = 1'b0;
    end
    // idle bus shows inverted last value
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk_in);
        reg_addr_out <= addr;
        reg_wdata_out <= data;
        reg_write_out <= 1'b1;
        @(negedge ref_clk_in);
        reg_write_out <= 1'b0;
        reg_addr_out <= ~addr;
        reg_wdata_out <= ~data;
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk_in);
        reg_addr_out <= addr;
        reg_read_out <= 1'b1;
        @(negedge ref_clk_in);
        data = reg_rdata_in;
        reg_read_out <= 1'b0;
        reg_addr_out <= ~addr;
    endtask
endmodule

// ---- test/pmic_telemetry_and_error_injection_tb_top.sv ----
// self-checking bench for the telemetry and error injection block
module pmic_telemetry_and_error_injection_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr, wdata, rdata, adc_code = 8'hA7, ia = 8'h5A, pa = 8'h60;
    logic wr, rd, hot = 1'b0, cmd = 1'b0, prog = 1'b0;
    logic [5:0] ib = 6'h2B, ic = 6'h15, pb = 6'h30, pc = 6'h20;
    logic [2:0] temp = 3'h5;
    logic [1:0] strap = 2'h0;
    logic adc_en, tconv, regs_en, off_start, inj, prog_out;
    logic [3:0] chan, id;
    logic [2:0] fstat;
    logic [7:0] v;
    int mismatches = 0;
    int n_tests = 0;
    logic [7:0] ro_tab [5] = '{8'h31, 8'h0C, 8'h0E, 8'h0F, 8'h33};
    logic [3:0] id_tab [4] = '{4'h9, 4'h8, 4'hC, 4'h8};

    always #50 clk = ~clk;

    host_bus_model u_host_bus_model (.ref_clk_in(clk), .reg_addr_out(addr), .reg_write_out(wr),
        .reg_wdata_out(wdata), .reg_read_out(rd), .reg_rdata_in(rdata));
    pmic_telemetry_and_error_injection u_pmic_telemetry_and_error_injection (
        .ref_clk_in(clk), .reset_n_in(reset_n), .reg_addr_in(addr), .reg_write_in(wr),
        .reg_wdata_in(wdata), .reg_read_in(rd), .reg_rdata_out(rdata), .adc_voltage_code_in(adc_code),
        .rail_a_buck_current_in(ia), .rail_b_buck_current_in(ib), .rail_c_buck_current_in(ic),
        .rail_a_buck_power_in(pa), .rail_b_buck_power_in(pb), .rail_c_buck_power_in(pc),
        .die_temp_code_in(temp), .die_temp_above_85c_in(hot), .address_id_strap_in(strap),
        .regulator_on_command_in(cmd), .programmable_mode_in(prog), .adc_enable_out(adc_en),
        .adc_channel_out(chan), .temp_convert_out(tconv), .address_id_out(id),
        .regulators_enable_out(regs_en), .power_off_start_out(off_start), .injection_mode_out(inj),
        .programmable_mode_out(prog_out), .fault_status_out(fstat));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
        u_host_bus_model.rd(a, v);
        check(v, exp);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset(input logic [1:0] s);
        @(negedge clk);
        strap = s;
        reset_n = 1'b0;
        cycles(2);
        reset_n = 1'b1;
        cycles(3);
    endtask
    task automatic pulse_cmd();
        @(negedge clk);
        cmd = 1'b1;
        @(negedge clk);
        cmd = 1'b0;
    endtask
    task automatic wait_on();
        int k;
        k = 0;
        while (regs_en !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        if (k == 10) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        cycles(2);
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            check({4'h0, id}, {4'h0, id_tab[i]});
        end
        $display("test strap done");
        for (int i = 0; i < 5; i++) u_host_bus_model.wr(ro_tab[i], 8'hFF);
        for (int i = 0; i < 5; i++) rcheck(ro_tab[i], 8'h00);
        rcheck(8'h07, 8'h00);
        rcheck(8'h30, 8'h00);
        $display("test readonly done");
        for (int c = 0; c < 6; c++) begin
            u_host_bus_model.wr(8'h30, {1'b1, c[3:0], 3'h0});
            check({3'h0, adc_en, chan}, {4'h1, c[3:0]});
            rcheck(8'h30, {1'b1, c[3:0], 3'h0});
        end
        check({7'h0, tconv}, 8'h01);
        cycles(2100);
        rcheck(8'h31, 8'hA7);
        rcheck(8'h33, 8'hA0);
        u_host_bus_model.wr(8'h30, 8'h00);
        hot = 1'b1;
        cycles(2);
        check({7'h0, tconv}, 8'h01);
        hot = 1'b0;
        $display("test adc done");
        u_host_bus_model.wr(8'h1B, 8'h00);
        u_host_bus_model.wr(8'h30, 8'h00);
        cycles(2100);
        rcheck(8'h0C, 8'h5A);
        rcheck(8'h0E, 8'h2B);
        rcheck(8'h0F, 8'h15);
        u_host_bus_model.wr(8'h1B, 8'h40);
        u_host_bus_model.wr(8'h30, 8'h00);
        cycles(2100);
        rcheck(8'h0C, 8'h60);
        rcheck(8'h0E, 8'h30);
        u_host_bus_model.wr(8'h1A, 8'h02);
        u_host_bus_model.wr(8'h30, 8'h00);
        cycles(2100);
        rcheck(8'h0C, 8'hB0);
        pa = 8'hF0;
        u_host_bus_model.wr(8'h30, 8'h00);
        cycles(2100);
        rcheck(8'h0C, 8'hFF);
        pa = 8'h10;
        u_host_bus_model.wr(8'h30, 8'h01);
        cycles(2100);
        rcheck(8'h0C, 8'hFF);
        cycles(2000);
        rcheck(8'h0C, 8'h60);
        $display("test telemetry done");
        for (int i = 0; i < 3; i++) begin
            do_reset(2'h0);
            prog = ~i[0];
            u_host_bus_model.wr(8'h2F, {5'h0, i[0], 2'h0});
            u_host_bus_model.wr(8'h35, 8'h80 | (8'h01 << i));
            pulse_cmd();
            cycles(5);
            check({7'h0, regs_en}, 8'h00);
            check({7'h0, prog_out}, {7'h0, i[0]});
            for (int a = 4; a < 7; a++) rcheck(a[7:0], 8'h00);
            u_host_bus_model.wr(8'h35, 8'h00);
            pulse_cmd();
            cycles(5);
            check({6'h0, inj, regs_en}, 8'h02);
        end
        $display("test pre on injection done");
        for (int i = 0; i < 3; i++) begin
            do_reset(2'h0);
            prog = 1'b0;
            pulse_cmd();
            wait_on();
            u_host_bus_model.wr(8'h35, 8'h81);
            cycles(3);
            check({6'h0, inj, regs_en}, 8'h01);
            prog = 1'b1;
            cycles(3);
            u_host_bus_model.wr(8'h35, 8'h80 | (8'h01 << i));
            cycles(1);
            check({7'h0, off_start}, 8'h01);
            cycles(2);
            check({5'h0, fstat}, 8'h01 << i);
            check({6'h0, inj, regs_en}, 8'h02);
            rcheck(8'h04, 8'h01 << i);
            rcheck(8'h05, 8'h01);
            rcheck(8'h06, 8'h01);
        end
        $display("test running injection done");
        summarize();
    end
endmodule

// ---- test/pmic_telemetry_sva.sv ----
// assertion checker for the telemetry and error injection block
module pmic_telemetry_sva (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic die_temp_above_85c_in,
    input wire logic regulator_on_command_in,
    input wire logic adc_enable_out,
    input wire logic [3:0] adc_channel_out,
    input wire logic temp_convert_out,
    input wire logic [3:0] address_id_out,
    input wire logic regulators_enable_out,
    input wire logic power_off_start_out,
    input wire logic injection_mode_out,
    input wire logic programmable_mode_out,
    input wire logic [2:0] fault_status_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_adc_write;
        reg_write_in && reg_addr_in == 8'h30 |=>
            adc_enable_out == $past(reg_wdata_in[7]) && adc_channel_out == $past(reg_wdata_in[6:3]);
    endproperty
    a_adc_write: assert property (p_adc_write) else $error("adc write lost");
    property p_temp_auto;
        die_temp_above_85c_in |-> temp_convert_out;
    endproperty
    a_temp_auto: assert property (p_temp_auto) else $error("no hot convert");
    property p_rdata_stands;
        !reg_read_in |=> $stable(reg_rdata_out);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("rdata moved");
    property p_on_after_cmd;
        $rose(regulators_enable_out) |-> $past(regulator_on_command_in, 2);
    endproperty
    a_on_after_cmd: assert property (p_on_after_cmd) else $error("on without cmd");
    property p_off_pulse;
        power_off_start_out |-> !regulators_enable_out && fault_status_out != 3'h0 && $past(regulators_enable_out);
    endproperty
    a_off_pulse: assert property (p_off_pulse) else $error("bad power off");
    property p_off_single;
        power_off_start_out |=> !power_off_start_out;
    endproperty
    a_off_single: assert property (p_off_single) else $error("long power off");
    property p_off_holds;
        !regulators_enable_out && fault_status_out != 3'h0 |=> !regulators_enable_out;
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("on after fault");
    property p_inj_held;
        injection_mode_out |=> injection_mode_out;
    endproperty
    a_inj_held: assert property (p_inj_held) else $error("inj left");
    property p_inj_refused;
        reg_write_in && reg_addr_in == 8'h35 && regulators_enable_out && !programmable_mode_out
            && !injection_mode_out |=> !injection_mode_out;
    endproperty
    a_inj_refused: assert property (p_inj_refused) else $error("secure inject");
    property p_id_code;
        address_id_out inside {4'h9, 4'h8, 4'hC};
    endproperty
    a_id_code: assert property (p_id_code) else $error("bad id");

    c_off: cover property (power_off_start_out);
    c_blocked: cover property ($rose(injection_mode_out) && !regulators_enable_out);
    c_on: cover property ($rose(regulators_enable_out));
endmodule

bind pmic_telemetry_and_error_injection pmic_telemetry_sva u_pmic_telemetry_sva (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .die_temp_above_85c_in(die_temp_above_85c_in),
    .regulator_on_command_in(regulator_on_command_in), .adc_enable_out(adc_enable_out),
    .adc_channel_out(adc_channel_out), .temp_convert_out(temp_convert_out),
    .address_id_out(address_id_out), .regulators_enable_out(regulators_enable_out),
    .power_off_start_out(power_off_start_out), .injection_mode_out(injection_mode_out),
    .programmable_mode_out(programmable_mode_out), .fault_status_out(fault_status_out)
);
